// [g711_law_compander_pkg.sv]
// Shared constants and types for the companding converter
package g711_law_compander_pkg;

   // Register byte offsets on the bus
   localparam logic [4:0]  LAW_SELECT_CFG_OFS = 5'h00;
   localparam logic [4:0]  LINEAR_IN_OFS      = 5'h04;
   localparam logic [4:0]  COMPANDED_IN_OFS   = 5'h08;
   localparam logic [4:0]  LINEAR_OUT_OFS     = 5'h0C;
   localparam logic [4:0]  COMPANDED_OUT_OFS  = 5'h10;

   // Field positions and reset values
   localparam int          LAW_MU_BIT         = 0;
   localparam logic        LAW_SELECT_RESET   = 1'b1;
   localparam logic [15:0] RESULT_RESET       = 16'h0000;

   // Segment table constants
   localparam logic [15:0] MU_CLIP            = 16'h1FDE;
   localparam logic [15:0] MU_BIAS            = 16'h0021;
   localparam logic [15:0] MU_DEC_BIAS        = 16'h0084;
   localparam logic [7:0]  MU_MASK_POS        = 8'hFF;
   localparam logic [7:0]  MU_MASK_NEG        = 8'h7F;
   localparam logic [7:0]  A_MASK_POS         = 8'hD5;
   localparam logic [7:0]  A_MASK_NEG         = 8'h55;
   localparam logic [15:0] A_SEG0_ROUND       = 16'h0008;
   localparam logic [15:0] A_SEGN_ROUND       = 16'h0108;

   // Register selection
   typedef enum {
      REG_CFG,
      REG_LIN_IN,
      REG_COMP_IN,
      REG_LIN_OUT,
      REG_COMP_OUT,
      REG_NONE
   } reg_sel_e;

   // Classic bus request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [31:0] adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_s;

endpackage : g711_law_compander_pkg

// [g711_law_compander.sv]
// Linear to companded and companded to linear converter with a bus slave
// Notes on behaviour
// R1 - Converts both directions, mu-law or A-law
// R2 - Config bit zero: one mu-law, zero A-law
// R3 - Reset selects mu-law
// R4 - Linear write yields companded result register
// R5 - Companded result holds until next linear write
// R6 - Companded write yields linear result register
// R7 - Inputs write-only 16-bit; results readable 16-bit
// R8 - Standard segment tables; result ready next cycle
`timescale 1ns/1ns

module g711_law_compander
   import g711_law_compander_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Register bus
   input  wire wb_req_s     wb_req_i,
   output logic             ack_o,
   output logic [31:0]      dat_o,
   // Status
   output logic             law_mu_o
);

   logic        law_mu;
   logic        next_law_mu;
   logic [15:0] companded_out;
   logic [15:0] next_companded;
   logic [15:0] linear_out;
   logic [15:0] next_linear;
   logic        ack;
   logic [31:0] rd_data;
   logic        req;
   logic        commit;
   logic        full_word;
   logic        wr_take;
   logic        wr_cfg;
   logic        wr_lin;
   logic        wr_comp;
   logic        rd_load;
   logic        rd_cfg;
   logic        rd_lin;
   logic        rd_comp;
   reg_sel_e    sel_reg;

   // Address decode
   function automatic reg_sel_e decode(input logic [31:0] adr);
      if (adr[31:5] != 27'h0) begin
         return REG_NONE;
      end else if (adr[4:0] == LAW_SELECT_CFG_OFS) begin
         return REG_CFG;
      end else if (adr[4:0] == LINEAR_IN_OFS) begin
         return REG_LIN_IN;
      end else if (adr[4:0] == COMPANDED_IN_OFS) begin
         return REG_COMP_IN;
      end else if (adr[4:0] == LINEAR_OUT_OFS) begin
         return REG_LIN_OUT;
      end else if (adr[4:0] == COMPANDED_OUT_OFS) begin
         return REG_COMP_OUT;
      end else begin
         return REG_NONE;
      end
   endfunction : decode

   // Segment of a biased mu-law magnitude
   function automatic logic [2:0] mu_segment(input logic [15:0] v);
      logic [2:0] seg;
      seg = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (v[i + 5]) begin
            seg = 3'(i);
         end
      end
      return seg;
   endfunction : mu_segment

   // Segment of an A-law magnitude
   function automatic logic [2:0] a_segment(input logic [15:0] v);
      logic [2:0] seg;
      seg = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (v[i + 4]) begin
            seg = 3'(i);
         end
      end
      return seg;
   endfunction : a_segment

   // Mu-law magnitude, clipped and biased
   function automatic logic [15:0] mu_magnitude(input logic [15:0] pcm);
      logic [15:0] v;
      v = {{2{pcm[15]}}, pcm[15:2]};
      if (pcm[15]) begin
         v = 16'(-v);
      end
      if (v > MU_CLIP) begin
         v = MU_CLIP;
      end
      return 16'(v + MU_BIAS);
   endfunction : mu_magnitude

   // A-law magnitude, inverted for negatives
   function automatic logic [15:0] a_magnitude(input logic [15:0] pcm);
      logic [15:0] v;
      v = {{3{pcm[15]}}, pcm[15:3]};
      if (pcm[15]) begin
         v = ~v;
      end
      return v;
   endfunction : a_magnitude

   // Linear to mu-law
   function automatic logic [7:0] mu_encode(input logic [15:0] pcm);
      logic [15:0] v;
      logic [2:0]  seg;
      logic [3:0]  mant;
      v    = mu_magnitude(pcm);
      seg  = mu_segment(v);
      mant = 4'(v >> ({1'b0, seg} + 4'h1));
      return {1'b0, seg, mant} ^ (pcm[15] ? MU_MASK_NEG : MU_MASK_POS);
   endfunction : mu_encode

   // Linear to A-law
   function automatic logic [7:0] a_encode(input logic [15:0] pcm);
      logic [15:0] v;
      logic [2:0]  seg;
      logic [3:0]  mant;
      v    = a_magnitude(pcm);
      seg  = a_segment(v);
      if (seg < 3'h2) begin
         mant = v[4:1];
      end else begin
         mant = 4'(v >> seg);
      end
      return {1'b0, seg, mant} ^ (pcm[15] ? A_MASK_NEG : A_MASK_POS);
   endfunction : a_encode

   // Mu-law to linear
   function automatic logic [15:0] mu_decode(input logic [7:0] code);
      logic [7:0]  u;
      logic [15:0] t;
      u = ~code;
      t = 16'(({8'h00, u[3:0], 3'h0} + MU_DEC_BIAS) << u[6:4]);
      if (u[7]) begin
         return 16'(MU_DEC_BIAS - t);
      end else begin
         return 16'(t - MU_DEC_BIAS);
      end
   endfunction : mu_decode

   // A-law to linear
   function automatic logic [15:0] a_decode(input logic [7:0] code);
      logic [7:0]  a;
      logic [15:0] t;
      a = code ^ A_MASK_NEG;
      t = {8'h00, a[3:0], 4'h0};
      if (a[6:4] == 3'h0) begin
         t = 16'(t + A_SEG0_ROUND);
      end else begin
         t = 16'((t + A_SEGN_ROUND) << (a[6:4] - 3'h1));
      end
      if (a[7]) begin
         return t;
      end else begin
         return 16'(-t);
      end
   endfunction : a_decode

   // Conversion in the selected law
   function automatic logic [7:0] compand(input logic mu, input logic [15:0] pcm);
      if (mu) begin
         return mu_encode(pcm);
      end else begin
         return a_encode(pcm);
      end
   endfunction : compand

   // Expansion in the selected law
   function automatic logic [15:0] expand(input logic mu, input logic [7:0] code);
      if (mu) begin
         return mu_decode(code);
      end else begin
         return a_decode(code);
      end
   endfunction : expand

   // Result placed in a bus word
   function automatic logic [31:0] result_word(input logic [15:0] r);
      return {16'h0000, r};
   endfunction : result_word

   // Bus handshake terms
   assign req       = wb_req_i.cyc && wb_req_i.stb;
   assign commit    = req && ack && ce_i;
   assign full_word = wb_req_i.sel[1:0] == 2'h3;
   assign sel_reg   = decode(wb_req_i.adr);
   assign rd_load   = ce_i && req && !ack;

   // Write strobes, one per writable register
   assign wr_take = commit && wb_req_i.we;
   assign wr_cfg  = wr_take && sel_reg == REG_CFG && wb_req_i.sel[0];
   assign wr_lin  = wr_take && sel_reg == REG_LIN_IN && full_word;
   assign wr_comp = wr_take && sel_reg == REG_COMP_IN && full_word;

   // Read selects
   assign rd_cfg  = sel_reg == REG_CFG;
   assign rd_lin  = sel_reg == REG_LIN_OUT;
   assign rd_comp = sel_reg == REG_COMP_OUT;

   // Registered acknowledge, one per request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
      end else if (ce_i) begin
         ack <= req && !ack;
      end
   end

   // Next law bit
   always_comb begin
      next_law_mu = law_mu;
      if (wr_cfg) begin
         next_law_mu = wb_req_i.dat[LAW_MU_BIT]; // R2
      end
   end

   // Law select register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         law_mu <= LAW_SELECT_RESET; // R3
      end else if (ce_i) begin
         law_mu <= next_law_mu;
      end
   end

   // Next companded result, only a linear write changes it
   always_comb begin
      next_companded = companded_out; // R5
      if (wr_lin) begin
         next_companded = {8'h00, compand(law_mu, wb_req_i.dat[15:0])}; // R4 R1 R8
      end
   end

   // Companded result register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         companded_out <= RESULT_RESET;
      end else if (ce_i) begin
         companded_out <= next_companded;
      end
   end

   // Next linear result, only a companded write changes it
   always_comb begin
      next_linear = linear_out;
      if (wr_comp) begin
         next_linear = expand(law_mu, wb_req_i.dat[7:0]); // R6 R1 R8
      end
   end

   // Linear result register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         linear_out <= RESULT_RESET;
      end else if (ce_i) begin
         linear_out <= next_linear;
      end
   end

   // Read data mux, write-only and unmapped read as zero
   always_comb begin
      rd_data = 32'h0000_0000;
      if (rd_cfg) begin
         rd_data = {31'h0000_0000, law_mu};
      end else if (rd_lin) begin
         rd_data = result_word(linear_out); // R7
      end else if (rd_comp) begin
         rd_data = result_word(companded_out); // R7
      end else begin
         rd_data = 32'h0000_0000;
      end
   end

   // Read data register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd_load) begin
         dat_o <= rd_data;
      end
   end

   // Bus acknowledge
   assign ack_o    = ack && req;
   // Law in force
   assign law_mu_o = law_mu;

endmodule : g711_law_compander

// [g711_law_compander_assertions.sv]
// Bus and law bit checks for the converter
`timescale 1ns/1ns
module g711_law_compander_chk
   import g711_law_compander_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire wb_req_s     wb_req_i,
   input wire logic        ack_o,
   input wire logic [31:0] dat_o,
   input wire logic        law_mu_o
);
   wire        req = wb_req_i.cyc & wb_req_i.stb;
   wire        wr  = ack_o & ce_i & wb_req_i.we;
   wire        rd  = ack_o & ~wb_req_i.we;
   wire [31:0] adr = wb_req_i.adr;
   wire        cfg = adr == 32'(LAW_SELECT_CFG_OFS);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_pulse: assert property (ack_o && ce_i |=> !ack_o)
      else $error("ack too long");
   chk_ack_cause: assert property (ack_o |-> req)
      else $error("ack without request");
   chk_ack_delay: assert property ($rose(req) && ce_i |=> ack_o)
      else $error("ack late");
   chk_law_reset: assert property ($past(rst_i) && $past(ce_i) |-> law_mu_o)
      else $error("law not mu after reset");
   chk_law_write: assert property (wr && cfg && wb_req_i.sel[0] |=>
      law_mu_o == $past(wb_req_i.dat[0]))
      else $error("law bit not written");
   chk_law_hold: assert property (!(wr && cfg) |=> $stable(law_mu_o))
      else $error("law bit changed");
   chk_wo_zero: assert property (rd && (adr == 32'(LINEAR_IN_OFS) ||
      adr == 32'(COMPANDED_IN_OFS)) |-> dat_o == 32'h0)
      else $error("input register readable");
   chk_upper_zero: assert property (rd |-> dat_o[31:16] == 16'h0)
      else $error("upper bits set");
   cover property (wr && adr == 32'(LINEAR_IN_OFS));
   cover property (rd && adr == 32'(COMPANDED_OUT_OFS));
   cover property (wr && cfg);
endmodule : g711_law_compander_chk
bind g711_law_compander g711_law_compander_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .wb_req_i(wb_req_i), .ack_o(ack_o), .dat_o(dat_o), .law_mu_o(law_mu_o));

// [dsp_bus_master.sv]
// Bus master model in place of the processor core
`timescale 1ns/1ns
module dsp_bus_master
   import g711_law_compander_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   output wb_req_s          wb_req_o
);
   initial wb_req_o = '0;
   task xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_i);
      wb_req_o <= '{1'b1, 1'b1, w, {27'h0, a}, 4'hF, d};
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i;
      wb_req_o <= '{1'b0, 1'b0, ~w, ~{27'h0, a}, 4'h0, ~d};
      @(posedge clk_i);
   endtask : xfer
endmodule : dsp_bus_master

// [g711_law_compander_tb.sv]
// Self-checking bench for the converter
`timescale 1ns/1ns
module g711_law_compander_tb import g711_law_compander_pkg::*;;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i  = 1'b1;
   logic        ack_o;
   logic        law_mu_o;
   logic [31:0] dat_o;
   logic [31:0] q;
   wb_req_s     wb_req;
   int          mismatches = 0;
   int          check_count = 0;
   logic [15:0] lin_v [2] = '{16'h0000, 16'h7FFF};
   logic [7:0]  code_v [4] = '{8'hFF, 8'h80, 8'hD5, 8'hAA};
   logic [15:0] dec_v [4] = '{16'h0000, 16'h7D7C, 16'h0008, 16'h7E00};
   always #20 clk_i = ~clk_i;
   g711_law_compander i_g711_law_compander (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wb_req_i(wb_req), .ack_o(ack_o), .dat_o(dat_o), .law_mu_o(law_mu_o));
   dsp_bus_master i_dsp_bus_master (.clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o),
      .wb_req_o(wb_req));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wr(input logic [4:0] a, input logic [31:0] d);
      i_dsp_bus_master.xfer(1'b1, a, d, q);
   endtask : wr
   task rd(input logic [4:0] a);
      i_dsp_bus_master.xfer(1'b0, a, 32'h0, q);
   endtask : rd
   task complete_run;
      if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   task t_reset;
      rd(LAW_SELECT_CFG_OFS);
      chk("cfg", q, 32'h1);
      chk("law", {31'h0, law_mu_o}, 32'h1);
   endtask : t_reset
   task t_convert;
      for (int l = 0; l < 2; l++) begin
         wr(LAW_SELECT_CFG_OFS, l ? 32'hFFFE : 32'h0001);
         chk("law", {31'h0, law_mu_o}, l ? 32'h0 : 32'h1);
         for (int i = 0; i < 2; i++) begin
            wr(LINEAR_IN_OFS, {16'h0, lin_v[i]});
            rd(COMPANDED_OUT_OFS);
            chk("comp", q, {24'h0, code_v[l*2+i]});
            wr(COMPANDED_IN_OFS, {24'h0, code_v[l*2+i]});
            rd(COMPANDED_OUT_OFS);
            chk("comp hold", q, {24'h0, code_v[l*2+i]});
            rd(LINEAR_OUT_OFS);
            chk("lin", q, {16'h0, dec_v[l*2+i]});
         end
      end
   endtask : t_convert
   task t_regs;
      rd(LINEAR_IN_OFS);
      chk("lin in", q, 32'h0);
      rd(COMPANDED_IN_OFS);
      chk("comp in", q, 32'h0);
      rd(5'h14);
      chk("unmapped", q, 32'h0);
      wr(COMPANDED_OUT_OFS, 32'h1234);
      rd(COMPANDED_OUT_OFS);
      chk("comp ro", q, 32'hAA);
   endtask : t_regs
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_convert;
      t_regs;
      complete_run;
   end
   initial begin
      repeat (2000) @(posedge clk_i);
      mismatches++;
      complete_run;
   end
endmodule : g711_law_compander_tb
